//--- core/mcu_ctrl_map.svh
// register map, bit positions, vectors and timing constants of the system control block
`ifndef MCU_CTRL_MAP_SVH
`define MCU_CTRL_MAP_SVH

`define REG_STATUS      6'h00
`define REG_XLO         6'h08
`define REG_CTRL        6'h09
`define REG_LO          6'h0A
`define REG_HI          6'h0B
`define REG_SUP_CTRL    6'h13
`define REG_SUP_LEVEL   6'h14
`define REG_WD_CLEAR    6'h1D

`define BIT_ZERO        0
`define BIT_CARRY       1
`define BIT_IRQ_FLAG    2
`define BIT_AUD_EN      0
`define BIT_GIE         1
`define BIT_SUP_EN      0
`define BIT_SUP_FLAG    1

`define VEC_RESET       14'h0000
`define VEC_WAKE        14'h0004
`define VEC_IRQ         14'h0008

`define SETTLE_CYCLES   7'h40
`define CLK_HZ          125000000
`define SAMPLE_HZ       32768
`define SAMPLE_HZ_FAST  65536
`define WATCHDOG_CYCLES (256*256*16)

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define NIB_RESET       4'h0

`endif

//--- core/mcu_ctrl_pkg.sv
// types shared by the system control block
package mcu_ctrl_pkg;
    typedef struct packed {
        logic [13:0] pc;
        logic [3:0]  code_page_high;
        logic [3:0]  memory_page_high;
        logic        carry_flag;
        logic        zero_flag;
    } cpu_ctx_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_SETTLE
    } mode_t;
endpackage

//--- core/pin_sync.sv
// three-stage synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] stable_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    wire  [W-1:0] nxt_q = (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff  <= '0;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign stable_o = q_ff;
endmodule
`default_nettype wire

//--- core/watchdog_counter.sv
// free-running watchdog counter with clear and one-cycle overflow pulse
`timescale 1ns/1ps
`default_nettype none
`include "mcu_ctrl_map.svh"
module watchdog_counter #(
    parameter int CYCLES = `WATCHDOG_CYCLES,
    parameter int CW     = 21
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    input  wire logic clear_i,
    output logic      overflow_o
);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_ff;
    logic          ovf_ff;
    wire           at_last = enable_i && (cnt_ff == LAST);
    wire  [CW-1:0] nxt_cnt = (clear_i || at_last || !enable_i) ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            ovf_ff <= at_last && !clear_i;
        end
    end

    assign overflow_o = ovf_ff;
endmodule
`default_nettype wire

//--- core/mcu_interrupt_halt_watchdog_ctrl.sv
// system control: sample interrupt, halt and wake sequencing, watchdog, supply detect
`timescale 1ns/1ps
`default_nettype none
`include "mcu_ctrl_map.svh"
module mcu_interrupt_halt_watchdog_ctrl #(
    parameter bit DOUBLE_RATE     = 1'b0,
    parameter bit TWELVE_BIT      = 1'b1,
    parameter bit DAC_PATH        = 1'b0,
    parameter bit WATCHDOG_ON     = 1'b1,
    parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_i,
    input  wire logic [7:0]             s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [7:0]             s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [31:0]                 s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i,
    input  wire mcu_ctrl_pkg::cpu_ctx_t cpu_ctx_i,
    input  wire logic                   halt_instr_i,
    input  wire logic                   return_from_irq_instr_i,
    output mcu_ctrl_pkg::cpu_ctx_t      restore_ctx_o,
    output logic                        restore_o,
    output logic                        pc_load_o,
    output logic [13:0]                 pc_value_o,
    output logic                        cpu_stall_o,
    output logic                        clk_stop_o,
    output logic                        sys_reset_o,
    output logic                        flag_write_o,
    output logic [1:0]                  flag_value_o,
    input  wire logic [15:0]            port_pins_i,
    input  wire logic [15:0]            wake_enable_i,
    input  wire logic                   supply_below_i,
    output logic [3:0]                  supply_level_o,
    output logic                        supply_detect_enable_o,
    output logic                        audio_out_enable_o,
    output logic                        sample_strobe_o,
    output logic                        sample_sign_o,
    output logic [11:0]                 pwm_sample_o,
    output logic [11:0]                 dac_sample_o
);
    import mcu_ctrl_pkg::*;

    localparam int SAMPLE_RATE = DOUBLE_RATE ? `SAMPLE_HZ_FAST : `SAMPLE_HZ;
    localparam int PERIOD      = `CLK_HZ / SAMPLE_RATE;
    localparam logic [11:0] PERIOD_LAST = 12'(PERIOD - 1);

    function automatic logic map_hit(input logic [5:0] idx);
        map_hit = (idx == `REG_STATUS) || (idx == `REG_XLO) || (idx == `REG_CTRL) ||
                  (idx == `REG_LO) || (idx == `REG_HI) || (idx == `REG_SUP_CTRL) ||
                  (idx == `REG_SUP_LEVEL) || (idx == `REG_WD_CLEAR);
    endfunction

    function automatic logic [11:0] build_sample(input logic [3:0] hi,
                                                 input logic [3:0] lo,
                                                 input logic [3:0] xl);
        if (TWELVE_BIT) begin
            build_sample = {hi, lo, xl};
        end else begin
            build_sample = {2'b00, hi, lo, xl[3:2]};
        end
    endfunction

    mode_t       mode_ff;
    cpu_ctx_t    ctx_ff;
    logic [6:0]  settle_ff;
    logic        take_ff, in_svc_ff, gie_ff, irq_flag_ff, aud_en_ff, restore_ff;
    logic        pc_load_ff, sup_en_ff, strobe_ff, flag_wr_ff;
    logic        aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
    logic [13:0] pc_vec_ff;
    logic [15:0] port_prev_ff;
    logic [3:0]  sup_level_ff, nib_hi_ff, nib_lo_ff, nib_xl_ff, wstrb_ff;
    logic [11:0] active_ff, div_ff;
    logic [1:0]  flag_val_ff, bresp_ff, rresp_ff;
    logic [5:0]  aw_idx_ff;
    logic [31:0] wdata_ff, rdata_ff;
    wire [15:0] port_s;
    wire        below_s;
    wire        wd_ovf;
    pin_sync #(.W(16)) u_port_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   (port_pins_i),
        .stable_o  (port_s)
    );
    pin_sync #(.W(1)) u_supply_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   (supply_below_i),
        .stable_o  (below_s)
    );
    // a watchdog overflow synchronously resets mode, interrupt, supply and sample-timer state; sample nibbles, flag value, context and bus state are kept
    wire soft_rst = wd_ovf;
    wire       aw_hs   = s_axi_awvalid_i && s_axi_awready_o;
    wire       w_hs    = s_axi_wvalid_i && s_axi_wready_o;
    wire       do_wr   = aw_ok_ff && w_ok_ff && !bvalid_ff;
    wire       wr_lane = do_wr && wstrb_ff[0];
    wire [3:0] wnib    = wdata_ff[3:0];
    wire       wr_stat = wr_lane && (aw_idx_ff == `REG_STATUS);
    wire       wr_ctrl = wr_lane && (aw_idx_ff == `REG_CTRL);
    wire       wr_xl   = wr_lane && (aw_idx_ff == `REG_XLO);
    wire       wr_lo   = wr_lane && (aw_idx_ff == `REG_LO);
    wire       wr_hi   = wr_lane && (aw_idx_ff == `REG_HI);
    wire       wr_sc   = wr_lane && (aw_idx_ff == `REG_SUP_CTRL);
    wire       wr_sl   = wr_lane && (aw_idx_ff == `REG_SUP_LEVEL);
    wire       wr_wd   = wr_lane && (aw_idx_ff == `REG_WD_CLEAR);
    wire       ar_hs  = s_axi_arvalid_i && s_axi_arready_o;
    wire [5:0] ar_idx = s_axi_araddr_i[7:2];
    wire       sup_flag = sup_en_ff && below_s;
    wire [3:0] stat_rd = {1'b0, irq_flag_ff, cpu_ctx_i.carry_flag, cpu_ctx_i.zero_flag};
    wire [3:0] rd_nib =
        (ar_idx == `REG_STATUS)    ? stat_rd :
        (ar_idx == `REG_CTRL)      ? {2'b00, gie_ff, aud_en_ff} :
        (ar_idx == `REG_SUP_CTRL)  ? {2'b00, sup_flag, sup_en_ff} :
        (ar_idx == `REG_SUP_LEVEL) ? sup_level_ff : `NIB_RESET;
    wire running    = (mode_ff == ST_RUN);
    wire halt_go    = running && halt_instr_i;
    wire wake_edge  = |((port_s ^ port_prev_ff) & wake_enable_i);
    wire settle_end = (mode_ff == ST_SETTLE) && (settle_ff == `SETTLE_CYCLES - 7'h01);
    mode_t nxt_mode;

    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            ST_RUN: begin
                if (halt_instr_i) begin
                    nxt_mode = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_edge) begin
                    nxt_mode = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (settle_end) begin
                    nxt_mode = ST_RUN;
                end
            end
        endcase
        if (soft_rst) begin
            nxt_mode = ST_SETTLE;
        end
    end

    wire [6:0] nxt_settle = (mode_ff == ST_SETTLE) ? settle_ff + 7'h01 : 7'h00;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff      <= ST_SETTLE;
            settle_ff    <= 7'h00;
            port_prev_ff <= 16'h0000;
        end else begin
            mode_ff      <= nxt_mode;
            settle_ff    <= soft_rst ? 7'h00 : nxt_settle;
            port_prev_ff <= port_s;
        end
    end
    wire want_irq = gie_ff && irq_flag_ff && running && !in_svc_ff && !take_ff;
    wire return_from_irq_instr_go  = running && in_svc_ff && return_from_irq_instr_i;
    wire period_end = aud_en_ff && running && (div_ff == PERIOD_LAST);

    wire nxt_gie  = return_from_irq_instr_go ? 1'b1 :
                    take_ff ? 1'b0 :
                    wr_ctrl ? wnib[`BIT_GIE] : gie_ff;
    // the flag is left alone on acceptance; a set in the cycle of a clear wins
    wire nxt_flag = period_end ? 1'b1 :
                    wr_stat ? wnib[`BIT_IRQ_FLAG] : irq_flag_ff;
    wire nxt_aud  = halt_go ? 1'b0 : wr_ctrl ? wnib[`BIT_AUD_EN] : aud_en_ff;
    wire [13:0] nxt_vec = take_ff ? `VEC_IRQ :
                          halt_go ? `VEC_WAKE : pc_vec_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            take_ff     <= 1'b0;
            in_svc_ff   <= 1'b0;
            gie_ff      <= 1'b0;
            irq_flag_ff <= 1'b0;
            aud_en_ff   <= 1'b0;
            ctx_ff      <= '0;
            restore_ff  <= 1'b0;
            pc_load_ff  <= 1'b1;
            pc_vec_ff   <= `VEC_RESET;
        end else if (soft_rst) begin
            take_ff     <= 1'b0;
            in_svc_ff   <= 1'b0;
            gie_ff      <= 1'b0;
            irq_flag_ff <= 1'b0;
            aud_en_ff   <= 1'b0;
            restore_ff  <= 1'b0;
            pc_load_ff  <= 1'b1;
            pc_vec_ff   <= `VEC_RESET;
        end else begin
            take_ff     <= want_irq;
            in_svc_ff   <= take_ff || (in_svc_ff && !return_from_irq_instr_go);
            gie_ff      <= nxt_gie;
            irq_flag_ff <= nxt_flag;
            aud_en_ff   <= nxt_aud;
            ctx_ff      <= take_ff ? cpu_ctx_i : ctx_ff;
            restore_ff  <= return_from_irq_instr_go;
            pc_load_ff  <= take_ff || halt_go;
            pc_vec_ff   <= nxt_vec;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sup_en_ff    <= 1'b0;
            sup_level_ff <= `NIB_RESET;
            flag_wr_ff   <= 1'b0;
            flag_val_ff  <= 2'b00;
        end else if (soft_rst) begin
            sup_en_ff    <= 1'b0;
            sup_level_ff <= `NIB_RESET;
            flag_wr_ff   <= 1'b0;
        end else begin
            sup_en_ff    <= wr_sc ? wnib[`BIT_SUP_EN] : sup_en_ff;
            sup_level_ff <= wr_sl ? wnib : sup_level_ff;
            flag_wr_ff   <= wr_stat;
            flag_val_ff  <= wr_stat ? {wnib[`BIT_CARRY], wnib[`BIT_ZERO]} : flag_val_ff;
        end
    end
    wire [11:0] nxt_div = (!aud_en_ff || !running || period_end) ? 12'h000 : div_ff + 12'h001;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nib_hi_ff <= `NIB_RESET;
            nib_lo_ff <= `NIB_RESET;
            nib_xl_ff <= `NIB_RESET;
            active_ff <= 12'h000;
            div_ff    <= 12'h000;
            strobe_ff <= 1'b0;
        end else begin
            nib_hi_ff <= wr_hi ? wnib : nib_hi_ff;
            nib_lo_ff <= wr_lo ? wnib : nib_lo_ff;
            nib_xl_ff <= wr_xl ? wnib : nib_xl_ff;
            if (period_end) begin
                active_ff <= build_sample(nib_hi_ff, nib_lo_ff, nib_xl_ff);
            end
            div_ff    <= soft_rst ? 12'h000 : nxt_div;
            strobe_ff <= period_end && !soft_rst;
        end
    end

    // watchdog: held clear whenever the core is not running
    wire wd_clear = wr_wd || !running;

    watchdog_counter #(.CYCLES(WATCHDOG_CYCLES)) u_watchdog (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .enable_i   (WATCHDOG_ON),
        .clear_i    (wd_clear),
        .overflow_o (wd_ovf)
    );

    // axi4-lite slave
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_ok_ff  <= 1'b0;
            aw_idx_ff <= 6'h00;
            w_ok_ff   <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end else begin
            aw_ok_ff  <= aw_hs || (aw_ok_ff && !do_wr);
            aw_idx_ff <= aw_hs ? s_axi_awaddr_i[7:2] : aw_idx_ff;
            w_ok_ff   <= w_hs || (w_ok_ff && !do_wr);
            wdata_ff  <= w_hs ? s_axi_wdata_i : wdata_ff;
            wstrb_ff  <= w_hs ? s_axi_wstrb_i : wstrb_ff;
            bvalid_ff <= do_wr || (bvalid_ff && !s_axi_bready_i);
            if (do_wr) begin
                bresp_ff <= map_hit(aw_idx_ff) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `RESP_OKAY;
        end else begin
            rvalid_ff <= ar_hs || (rvalid_ff && !s_axi_rready_i);
            if (ar_hs) begin
                rdata_ff <= {28'h000_0000, rd_nib};
                rresp_ff <= map_hit(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready_o = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready_o  = !w_ok_ff && !bvalid_ff;
    assign s_axi_bvalid_o  = bvalid_ff;
    assign s_axi_bresp_o   = bresp_ff;
    assign s_axi_arready_o = !rvalid_ff;
    assign s_axi_rvalid_o  = rvalid_ff;
    assign s_axi_rdata_o   = rdata_ff;
    assign s_axi_rresp_o   = rresp_ff;
    assign restore_ctx_o = ctx_ff;
    assign restore_o     = restore_ff;
    assign pc_load_o     = pc_load_ff;
    assign pc_value_o    = pc_vec_ff;
    assign cpu_stall_o   = !running;
    assign clk_stop_o    = (mode_ff == ST_HALT);
    assign sys_reset_o   = wd_ovf;
    assign flag_write_o  = flag_wr_ff;
    assign flag_value_o  = flag_val_ff;

    assign supply_level_o         = sup_level_ff;
    assign supply_detect_enable_o = sup_en_ff;
    assign audio_out_enable_o     = aud_en_ff;
    assign sample_strobe_o        = strobe_ff;
    assign sample_sign_o          = TWELVE_BIT ? active_ff[11] : active_ff[9];
    assign pwm_sample_o           = DAC_PATH ? 12'h000 : active_ff;
    assign dac_sample_o           = DAC_PATH ? active_ff : 12'h000;
endmodule
`default_nettype wire

//--- verification/ctrl_checker.sv
// concurrent checks on the system control block ports
`timescale 1ns/1ps
`default_nettype none
`include "mcu_ctrl_map.svh"
module ctrl_checker (
    input wire logic                   ref_clk_i,
    input wire logic                   rst_i,
    input wire mcu_ctrl_pkg::cpu_ctx_t cpu_ctx_i,
    input wire logic                   halt_instr_i,
    input wire mcu_ctrl_pkg::cpu_ctx_t restore_ctx_o,
    input wire logic                   restore_o,
    input wire logic                   pc_load_o,
    input wire logic [13:0]            pc_value_o,
    input wire logic                   cpu_stall_o,
    input wire logic                   clk_stop_o,
    input wire logic                   sys_reset_o,
    input wire logic                   sample_strobe_o,
    input wire logic                   audio_out_enable_o
);
    import mcu_ctrl_pkg::*;
    localparam int PERIOD = 3814;
    logic [6:0]  settle_ff;
    logic [12:0] per_ff;
    logic        seen_ff;
    logic        svc_ff;
    cpu_ctx_t    saved_ff;
    wire irq_load = pc_load_o && !cpu_stall_o && pc_value_o == `VEC_IRQ;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_ff <= 7'h00;
            per_ff    <= 13'h0000;
            seen_ff   <= 1'b0;
            svc_ff    <= 1'b0;
            saved_ff  <= '0;
        end else begin
            settle_ff <= (cpu_stall_o && !clk_stop_o) ? settle_ff + 7'h01 : 7'h00;
            per_ff    <= sample_strobe_o ? 13'h0001 : per_ff + 13'h0001;
            seen_ff   <= audio_out_enable_o && (seen_ff || sample_strobe_o);
            svc_ff    <= (svc_ff || irq_load) && !restore_o && !sys_reset_o;
            if (irq_load)
                saved_ff <= $past(cpu_ctx_i);
        end
    end
    sequence halt_entry;
        pc_load_o && pc_value_o == `VEC_WAKE && clk_stop_o && cpu_stall_o;
    endsequence
    sequence reset_entry;
        pc_load_o && pc_value_o == `VEC_RESET && cpu_stall_o;
    endsequence
    a_halt_entry: assert property (halt_instr_i && !cpu_stall_o |=> halt_entry)
        else $error("halt entry wrong");
    a_irq_vector: assert property (pc_load_o && !cpu_stall_o && !sys_reset_o |-> irq_load)
        else $error("running load not irq vector");
    a_take_ctx: assert property (irq_load |-> restore_ctx_o == $past(cpu_ctx_i))
        else $error("context not saved");
    a_no_nest: assert property (irq_load |-> !svc_ff)
        else $error("nested irq taken");
    a_restore_ctx: assert property (restore_o |-> svc_ff && restore_ctx_o == saved_ff)
        else $error("restore context wrong");
    a_settle_len: assert property ($fell(cpu_stall_o) |-> settle_ff == 7'h40)
        else $error("settle length wrong");
    a_wd_reset: assert property (sys_reset_o |-> ##[0:1] reset_entry)
        else $error("overflow did not reset");
    a_sample_period: assert property (sample_strobe_o && seen_ff |-> per_ff == PERIOD)
        else $error("sample period wrong");
endmodule
bind mcu_interrupt_halt_watchdog_ctrl ctrl_checker u_ctrl_checker (.ref_clk_i, .rst_i,
    .cpu_ctx_i, .halt_instr_i, .restore_ctx_o, .restore_o, .pc_load_o, .pc_value_o, .cpu_stall_o,
    .clk_stop_o, .sys_reset_o, .sample_strobe_o, .audio_out_enable_o);
`default_nettype wire

//--- verification/cpu_model.sv
// behavioural cpu core: runs pc, services the irq, halts on request
`timescale 1ns/1ps
`default_nettype none
`include "mcu_ctrl_map.svh"
module cpu_model (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              stall_i,
    input  wire logic              pc_load_i,
    input  wire logic [13:0]       pc_value_i,
    input  wire logic              halt_req_i,
    output mcu_ctrl_pkg::cpu_ctx_t ctx_o,
    output logic                   halt_o,
    output logic                   return_from_irq_instr_o
);
    import mcu_ctrl_pkg::*;
    logic [5:0] svc_ff;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctx_o  <= 24'h000002;
            svc_ff <= 6'h00;
            halt_o <= 1'b0;
            return_from_irq_instr_o <= 1'b0;
        end else begin
            halt_o <= halt_req_i && !stall_i;
            return_from_irq_instr_o <= svc_ff == 6'h01;
            ctx_o.code_page_high   <= ctx_o.pc[3:0];
            ctx_o.memory_page_high <= ctx_o.pc[7:4];
            if (pc_load_i)
                ctx_o.pc <= pc_value_i;
            else if (!stall_i)
                ctx_o.pc <= ctx_o.pc + 14'h0001;
            if (pc_load_i && pc_value_i == `VEC_IRQ)
                svc_ff <= 6'h30;
            else if (svc_ff != 6'h00)
                svc_ff <= svc_ff - 6'h01;
        end
    end
endmodule
`default_nettype wire

//--- verification/mcu_interrupt_halt_watchdog_ctrl_bench.sv
// self-checking bench for the system control block
`timescale 1ns/1ps
`default_nettype none
`include "mcu_ctrl_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mcu_interrupt_halt_watchdog_ctrl_bench;
    import mcu_ctrl_pkg::*;
    localparam int WD = 6000;
    logic        ref_clk_i = 1'b0, rst_i = 1'b1, halt_req = 1'b0, supply_below_i = 1'b0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic        s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [15:0] port_pins_i = 16'h0, wake_enable_i = 16'h0;
    wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire         halt_instr_i, return_from_irq_instr_i, restore_o, pc_load_o, cpu_stall_o;
    wire         clk_stop_o, sys_reset_o, sample_strobe_o, sample_sign_o, supply_detect_enable_o;
    wire [3:0]   supply_level_o;
    wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0]  s_axi_rdata_o;
    wire [13:0]  pc_value_o;
    wire [11:0]  pwm_sample_o;
    cpu_ctx_t    cpu_ctx_i;
    int          n_errors = 0, n_checks = 0, cyc = 0;
    logic [5:0]  q_bus[$], e_bus;
    logic [13:0] q_pc[$], e_pc;
    logic [12:0] q_smp[$], e_smp;
    always #4 ref_clk_i = ~ref_clk_i;
    mcu_interrupt_halt_watchdog_ctrl #(.WATCHDOG_CYCLES(WD)) u_mcu_interrupt_halt_watchdog_ctrl (
        .ref_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .cpu_ctx_i, .halt_instr_i,
        .return_from_irq_instr_i, .restore_ctx_o(), .restore_o, .pc_load_o, .pc_value_o,
        .cpu_stall_o, .clk_stop_o, .sys_reset_o, .flag_write_o(), .flag_value_o(), .port_pins_i,
        .wake_enable_i, .supply_below_i, .supply_level_o, .supply_detect_enable_o,
        .audio_out_enable_o(), .sample_strobe_o, .sample_sign_o, .pwm_sample_o, .dac_sample_o());
    cpu_model u_cpu_model (.ref_clk_i, .rst_i, .stall_i(cpu_stall_o), .pc_load_i(pc_load_o),
        .pc_value_i(pc_value_o), .halt_req_i(halt_req), .ctx_o(cpu_ctx_i), .halt_o(halt_instr_i),
        .return_from_irq_instr_o(return_from_irq_instr_i));
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
        if ((s_axi_rvalid_o && s_axi_rready_i) || (s_axi_bvalid_o && s_axi_bready_i)) begin
            e_bus = q_bus.pop_front();
            if (s_axi_rvalid_o) `CHK({s_axi_rresp_o, s_axi_rdata_o[3:0]}, e_bus)
            else `CHK({s_axi_bresp_o, 4'h0}, e_bus)
        end
        if (!rst_i && pc_load_o) begin
            e_pc = q_pc.pop_front();
            `CHK(pc_value_o, e_pc)
        end
        if (sample_strobe_o) begin
            e_smp = q_smp.pop_front();
            `CHK({sample_sign_o, pwm_sample_o}, e_smp)
        end
    end
    task automatic wr(input logic [5:0] idx, input logic [3:0] d, input logic [1:0] rsp);
        q_bus.push_back({rsp, 4'h0});
        s_axi_awaddr_i <= {idx, 2'b00};
        s_axi_wdata_i <= {28'h0, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_awvalid_i || s_axi_wvalid_i);
        do @(posedge ref_clk_i); while (!s_axi_bvalid_o);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [5:0] exp);
        q_bus.push_back(exp);
        s_axi_araddr_i <= {idx, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        do @(posedge ref_clk_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge ref_clk_i); while (!s_axi_rvalid_o);
    endtask
    initial begin
        logic [3:0] hi, lo, xl, lvl;
        logic       b;
        int         n;
        void'($urandom(7));
        {hi, lo, xl, lvl} = $urandom;
        b = $urandom;
        supply_below_i <= b;
        wake_enable_i <= 16'h0001 << ($urandom % 16);
        repeat (8) @(posedge ref_clk_i);
        q_pc.push_back(`VEC_RESET);
        rst_i <= 1'b0;
        do @(posedge ref_clk_i); while (cpu_stall_o);
        rd(`REG_CTRL, 6'h00);
        rd(`REG_SUP_LEVEL, 6'h00);
        rd(6'h15, {`RESP_SLVERR, 4'h0});
        wr(6'h16, 4'hF, `RESP_SLVERR);
        wr(`REG_SUP_LEVEL, lvl, `RESP_OKAY);
        rd(`REG_SUP_LEVEL, {2'h0, lvl});
        wr(`REG_SUP_CTRL, 4'h1, `RESP_OKAY);
        `CHK({supply_detect_enable_o, supply_level_o}, {1'b1, lvl})
        rd(`REG_SUP_CTRL, {4'h0, b, 1'b1});
        wr(`REG_HI, hi, `RESP_OKAY);
        wr(`REG_LO, lo, `RESP_OKAY);
        wr(`REG_XLO, xl, `RESP_OKAY);
        wr(`REG_WD_CLEAR, 4'h0, `RESP_OKAY);
        q_smp.push_back({hi[3], hi, lo, xl});
        q_smp.push_back({hi[3], hi, lo, xl});
        q_pc.push_back(`VEC_IRQ);
        wr(`REG_CTRL, 4'h3, `RESP_OKAY);
        do @(posedge ref_clk_i); while (!sample_strobe_o);
        repeat (3) @(posedge ref_clk_i);
        rd(`REG_CTRL, 6'h01);
        rd(`REG_STATUS, 6'h06);
        wr(`REG_STATUS, 4'h0, `RESP_OKAY);
        do @(posedge ref_clk_i); while (!restore_o);
        rd(`REG_CTRL, 6'h03);
        wr(`REG_CTRL, 4'h1, `RESP_OKAY);
        wr(`REG_WD_CLEAR, 4'h0, `RESP_OKAY);
        do @(posedge ref_clk_i); while (!sample_strobe_o);
        repeat (3) @(posedge ref_clk_i);
        rd(`REG_STATUS, 6'h06);
        wr(`REG_STATUS, 4'h0, `RESP_OKAY);
        q_pc.push_back(`VEC_WAKE);
        halt_req <= 1'b1;
        @(posedge ref_clk_i);
        halt_req <= 1'b0;
        do @(posedge ref_clk_i); while (!clk_stop_o);
        repeat (4) @(posedge ref_clk_i);
        port_pins_i <= wake_enable_i;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (cpu_stall_o);
        `CHK(n > 64 && n < 75, 1'b1)
        n = 0;
        q_pc.push_back(`VEC_RESET);
        do begin @(posedge ref_clk_i); n++; end while (!sys_reset_o);
        `CHK(n >= WD - 3 && n <= WD + 3, 1'b1)
        repeat (2) @(posedge ref_clk_i);
        do @(posedge ref_clk_i); while (cpu_stall_o);
        rd(`REG_CTRL, 6'h00);
        rd(`REG_SUP_LEVEL, 6'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
